// File: hw/spu_pkg.sv
/*
 * spu_pkg: constants and types shared by the serial port unit files.
 * Assumes a single 250 MHz clock and an 8N1 asynchronous line format.
 */
package spu_pkg;
    // clocking and average rate
    localparam longint CLK_HZ       = 250_000_000;
    localparam longint AVG_RATE_BPS = 921_569;
    localparam longint OVERSAMPLE   = 16;
    localparam int     PHASE_W      = 32;
    localparam logic [PHASE_W-1:0] AVG_PHASE_INC =
        PHASE_W'(((AVG_RATE_BPS * OVERSAMPLE) << PHASE_W) / CLK_HZ);
    // ordinary generator: ref_clk cycles per oversample tick
    localparam int     STD_TICK_DIV = 136;
    // frame shape
    localparam int     DATA_BITS    = 8;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID  = 4'h7;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    // block exchange
    localparam int     BLOCK_BYTES  = 128;
    localparam logic [6:0] BLOCK_LAST = 7'h7F;
    localparam int     FIFO_DEPTH   = 32;
    // status flag positions and reset value
    localparam int     NUM_FLAGS    = 5;
    localparam int     FLG_TXE      = 0;
    localparam int     FLG_RXF      = 1;
    localparam int     FLG_ORR      = 2;
    localparam int     FLG_PAR      = 3;
    localparam int     FLG_FRM      = 4;
    localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 5'h01;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} spu_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spu_rx_t;
endpackage

// File: hw/spu_stream_if.sv
/*
 * spu_stream_if: valid/ready byte stream between the unit's own modules.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ps
interface spu_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: hw/spu_fifo.sv
/*
 * spu_fifo: synchronous FIFO with registered full and empty.
 * Assumes one clock; read data is valid whenever rd.valid is high.
 */
`timescale 1ns/1ps
module spu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic   ref_clk,
    input  wire logic   arst_n,
    // fill and drain sides
    spu_stream_if.snk   wr,
    spu_stream_if.src   rd
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic             full_reg;
    logic             empty_reg;
    wire              push = wr.valid & ~full_reg;
    wire              pop  = rd.ready & ~empty_reg;

    // handshake from registered level flags
    assign wr.ready   = ~full_reg;
    assign rd.valid   = ~empty_reg;
    assign rd.data    = mem[rdPtr_reg];
    assign count_next = count_reg + CW'(push) - CW'(pop);

    // storage
    always_ff @(posedge ref_clk) begin
        if (push) mem[wrPtr_reg] <= wr.data;
    end

    // pointers and occupancy
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            full_reg  <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            if (push) wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0
                                                            : wrPtr_reg + 1'b1;
            if (pop)  rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0
                                                            : rdPtr_reg + 1'b1;
            count_reg <= count_next;
            full_reg  <= (count_next == CW'(DEPTH));
            empty_reg <= (count_next == '0);
        end
    end
endmodule // spu_fifo

// File: hw/spu_serial_port_unit.sv
/*
 * spu_serial_port_unit: 8N1 asynchronous transmitter and receiver with an
 * average-rate bit clock, double buffers, status flags and request pulses
 * for two outside DMA channels, plus the trigger handshake for blocks.
 * Assumes all inputs synchronous to ref_clk; DMA lives outside.
 */
`timescale 1ns/1ps
// Function
// - an input selects the average-rate generator instead of the plain one.
// - with the average generator both ends run at 921.569 kbps on average.
// - frames carry eight data bits, no parity and one stop bit, LSB first.
// - after reset the initiator drives its trigger low, then starts blocks.
// - the responder starts its blocks on a low level at its trigger input.
// - a held byte moves to the free shift register and is sent on the pin.
// - each move from holding to shift register pulses the empty request.
// - an error-free received frame is copied into the receive holding register when it is empty.
// - the full request pulses only after an error-free frame is copied.
// - receive shift and holding registers form a double buffer.
// - status flags are clearable by software and never set by it.
module spu_serial_port_unit
    import spu_pkg::*;
#(
    parameter int STD_DIV = STD_TICK_DIV
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    // configuration levels
    input  wire logic                 avgRateSel,
    input  wire logic                 initiatorStrap,
    // trigger pins
    input  wire logic                 triggerInPin,
    output logic                      triggerOutPin,
    // serial pins
    input  wire logic                 serialInPin,
    output logic                      serialOutPin,
    // transmit byte stream from memory side
    input  wire logic                 txInValid,
    input  wire logic [7:0]           txInData,
    output logic                      txInReady,
    // received byte and its read strobe
    output logic [7:0]                rxData,
    input  wire logic                 rxReadStrobe,
    // status flags and requests
    input  wire logic [NUM_FLAGS-1:0] flagClear,
    output logic [NUM_FLAGS-1:0]      statusFlags,
    output logic                      txEmptyRequest,
    output logic                      rxFullRequest,
    // block progress
    output logic                      blockActive,
    output logic                      txBlockDone,
    output logic                      rxBlockDone
);
    import spu_pkg::*;

    logic [PHASE_W-1:0]   phase_reg;
    logic [15:0]          stdCnt_reg;
    logic                 tick_reg;
    logic                 strapDone_reg, isInit_reg;
    logic                 txHoldFull_reg;
    logic [7:0]           txHold_reg, txShift_reg, rxShift_reg;
    logic [3:0]           txCnt_reg, rxCnt_reg;
    logic [2:0]           txBit_reg, rxBit_reg;
    logic [6:0]           txBytes_reg, rxBytes_reg;
    spu_tx_t              txState, txState_next;
    spu_rx_t              rxState, rxState_next;
    logic [NUM_FLAGS-1:0] setVec, clrVec, flags_next;

    spu_stream_if #(.WIDTH(8)) fillIf ();
    spu_stream_if #(.WIDTH(8)) drainIf ();

    // transmit FIFO in front of the holding register
    assign fillIf.valid  = txInValid;
    assign fillIf.data   = txInData;
    assign txInReady     = fillIf.ready;
    assign drainIf.ready = ~txHoldFull_reg;
    spu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .wr      (fillIf),
        .rd      (drainIf)
    );

    // rate generators: fractional accumulator or integer divider
    wire [PHASE_W:0] phaseSum = {1'b0, phase_reg} + {1'b0, AVG_PHASE_INC};
    wire             stdWrap  = (stdCnt_reg == 16'(STD_DIV - 1));
    wire             tickSrc  = avgRateSel ? phaseSum[PHASE_W] : stdWrap;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg  <= '0;
            stdCnt_reg <= '0;
            tick_reg   <= 1'b0;
        end else begin
            phase_reg  <= phaseSum[PHASE_W-1:0];
            stdCnt_reg <= stdWrap ? '0 : stdCnt_reg + 16'h0001;
            tick_reg   <= tickSrc;
        end
    end

    // role strap caught after release, trigger and block start
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            strapDone_reg <= 1'b0;
            isInit_reg    <= 1'b0;
            triggerOutPin <= 1'b1;
            blockActive   <= 1'b0;
        end else begin
            strapDone_reg <= 1'b1;
            if (!strapDone_reg) isInit_reg <= initiatorStrap;
            if (strapDone_reg && isInit_reg) triggerOutPin <= 1'b0;
            if (strapDone_reg && ((isInit_reg && !triggerOutPin)
                || (!isInit_reg && !triggerInPin)))
                blockActive <= 1'b1;
        end
    end

    // transmit decode
    wire txMove   = (txState == TX_IDLE) & txHoldFull_reg & blockActive;
    wire txBitEnd = tick_reg & (txCnt_reg == TICK_LAST);
    wire txPop    = drainIf.valid & ~txHoldFull_reg;
    always_comb begin
        txState_next = txState;
        case (txState)
            TX_IDLE:  if (txMove) txState_next = TX_START;
            TX_START: if (txBitEnd) txState_next = TX_DATA;
            TX_DATA:  if (txBitEnd && txBit_reg == BIT_LAST)
                          txState_next = TX_STOP;
            TX_STOP:  if (txBitEnd) txState_next = TX_IDLE;
            default:  txState_next = TX_IDLE;
        endcase
    end

    // transmit holding, shift register and line driver
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            txState <= TX_IDLE;
            txHoldFull_reg <= 1'b0;
            txHold_reg <= '0;
            txShift_reg <= '0;
            txCnt_reg <= '0;
            txBit_reg <= '0;
            serialOutPin <= 1'b1;
        end else begin
            txState <= txState_next;
            if (txPop) txHold_reg <= drainIf.data;
            if (txPop) txHoldFull_reg <= 1'b1;
            else if (txMove) txHoldFull_reg <= 1'b0;
            if (txMove) txShift_reg <= txHold_reg;
            else if (txState == TX_DATA && txBitEnd)
                txShift_reg <= {1'b0, txShift_reg[7:1]};
            txCnt_reg <= (txState == TX_IDLE) ? '0 : txCnt_reg + 4'(tick_reg);
            if (txState != TX_DATA) txBit_reg <= '0;
            else if (txBitEnd) txBit_reg <= txBit_reg + 3'h1;
            serialOutPin <= (txState == TX_START) ? 1'b0 :
                            (txState == TX_DATA)  ? txShift_reg[0] : 1'b1;
        end
    end

    // receive decode
    wire rxStartLow = (rxState == RX_IDLE) & ~serialInPin & blockActive;
    wire rxMid      = tick_reg & (rxCnt_reg == TICK_MID);
    wire rxBitEnd   = tick_reg & (rxCnt_reg == TICK_LAST);
    wire rxFrameEnd = (rxState == RX_STOP) & rxBitEnd;
    wire rxGood     = rxFrameEnd & serialInPin;
    wire rxCopy     = rxGood & ~statusFlags[FLG_RXF];
    always_comb begin
        rxState_next = rxState;
        case (rxState)
            RX_IDLE:  if (rxStartLow) rxState_next = RX_START;
            RX_START: if (rxMid) rxState_next = serialInPin ? RX_IDLE : RX_DATA;
            RX_DATA:  if (rxBitEnd && rxBit_reg == BIT_LAST)
                          rxState_next = RX_STOP;
            RX_STOP:  if (rxBitEnd) rxState_next = RX_IDLE;
            default:  rxState_next = RX_IDLE;
        endcase
    end

    // receive sampling and copy into the holding register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxState <= RX_IDLE;
            rxShift_reg <= '0;
            rxCnt_reg <= '0;
            rxBit_reg <= '0;
            rxData <= '0;
        end else begin
            rxState <= rxState_next;
            if (rxState == RX_IDLE || (rxState == RX_START && rxMid))
                rxCnt_reg <= '0; // realign on the start bit centre
            else
                rxCnt_reg <= rxCnt_reg + 4'(tick_reg);
            if (rxState == RX_DATA && rxBitEnd)
                rxShift_reg <= {serialInPin, rxShift_reg[7:1]};
            if (rxState != RX_DATA) rxBit_reg <= '0;
            else if (rxBitEnd) rxBit_reg <= rxBit_reg + 3'h1;
            if (rxCopy) rxData <= rxShift_reg;
        end
    end

    // flag set and clear terms; set wins over clear
    assign setVec[FLG_TXE] = txMove;
    assign setVec[FLG_RXF] = rxCopy;
    assign setVec[FLG_ORR] = rxGood & statusFlags[FLG_RXF];
    assign setVec[FLG_PAR] = 1'b0; // no parity in this format
    assign setVec[FLG_FRM] = rxFrameEnd & ~serialInPin;
    assign clrVec = flagClear | {3'h0, rxReadStrobe, txPop};
    assign flags_next = setVec | (statusFlags & ~clrVec);

    // flags, requests and block byte counts
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            statusFlags <= FLAGS_RESET;
            txEmptyRequest <= 1'b0;
            rxFullRequest <= 1'b0;
            txBytes_reg <= '0;
            rxBytes_reg <= '0;
            txBlockDone <= 1'b0;
            rxBlockDone <= 1'b0;
        end else begin
            statusFlags <= flags_next;
            txEmptyRequest <= txMove;
            rxFullRequest <= rxCopy;
            if (txMove) txBytes_reg <= txBytes_reg + 7'h01;
            if (rxCopy) rxBytes_reg <= rxBytes_reg + 7'h01;
            txBlockDone <= txMove & (txBytes_reg == BLOCK_LAST);
            rxBlockDone <= rxCopy & (rxBytes_reg == BLOCK_LAST);
        end
    end

    // helper: cycles since the previous oversample tick
    logic [7:0] gap_reg;
    logic       seen_reg;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_reg  <= '0;
            seen_reg <= 1'b0;
        end else begin
            gap_reg  <= tick_reg ? 8'h01 : gap_reg + 8'h01;
            if (tick_reg) seen_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_move;
        txState == TX_IDLE && txHoldFull_reg && blockActive;
    endsequence
    sequence s_start_out;
        txEmptyRequest && txState == TX_START ##1 !serialOutPin;
    endsequence

    a_tx_move_req: assert property (s_move |=> s_start_out)
        else $error("move did not pulse request and start bit");
    a_tx_shift_load: assert property (s_move
        |=> txShift_reg == $past(txHold_reg))
        else $error("shift register not loaded from holding");
    a_line_idle_high: assert property (txState == TX_IDLE
        |=> serialOutPin)
        else $error("line not high while idle");
    a_tx_stop_after8: assert property (txState == TX_DATA && txBitEnd
        && txBit_reg == BIT_LAST |=> txState == TX_STOP ##1 serialOutPin)
        else $error("stop bit not after eighth data bit");
    a_rx_copy_req: assert property (rxFullRequest
        |-> statusFlags[FLG_RXF] && rxData == $past(rxShift_reg)
        && !$past(statusFlags[FLG_RXF]))
        else $error("full request without a clean copy");
    a_rx_frame_err: assert property ($rose(statusFlags[FLG_FRM])
        |-> !rxFullRequest && $past(rxState) == RX_STOP)
        else $error("framing error outside stop bit or with request");
    a_rx_overrun: assert property ($rose(statusFlags[FLG_ORR])
        |-> $past(statusFlags[FLG_RXF]) && $stable(rxData))
        else $error("overrun without held byte or holding overwritten");
    a_no_sw_set: assert property ($rose(statusFlags[FLG_TXE])
        |-> $past(txMove))
        else $error("empty flag set without a move");
    a_init_trigger: assert property (strapDone_reg && isInit_reg
        && !blockActive |=> !triggerOutPin ##1 blockActive)
        else $error("initiator did not trigger then start");
    a_resp_start: assert property (strapDone_reg && !isInit_reg
        && !triggerInPin |=> blockActive)
        else $error("responder did not start on low trigger");
    a_avg_tick_gap: assert property (tick_reg && seen_reg && avgRateSel
        && $past(avgRateSel, 20) |-> gap_reg inside {8'h10, 8'h11})
        else $error("average tick spacing outside 16 to 17 cycles");
    a_std_tick_src: assert property (!avgRateSel && !$past(avgRateSel)
        && tick_reg |-> $past(stdWrap))
        else $error("tick not from plain divider when deselected");
endmodule // spu_serial_port_unit

// File: tb/spu_peer_model.sv
/*
 * spu_peer_model: behavioural far-end serial port, 8N1, LSB first.
 * Assumes the bench sets bitNs to the bit time the unit is using.
 */
`timescale 1ns/1ps
module spu_peer_model (
    // line from the unit and line toward it
    input  wire logic lineFromUnit,
    output logic      lineToUnit
);
    realtime    bitNs = 128.0;
    logic [8:0] got[$];
    logic [8:0] frame;

    // line idles high until a frame is sent
    initial lineToUnit = 1'b1;

    // one frame; stopLvl low makes a framing fault on purpose
    task automatic send(input logic [7:0] d, input logic stopLvl);
        lineToUnit = 1'b0;
        #(bitNs);
        for (int i = 0; i < 8; i++) begin
            lineToUnit = d[i];
            #(bitNs);
        end
        lineToUnit = stopLvl;
        #(bitNs);
        lineToUnit = 1'b1;
        #(bitNs);
    endtask

    // receiver: align on start edge, keep {stop, data}
    always @(negedge lineFromUnit) begin
        #(bitNs / 2);
        if (lineFromUnit == 1'b0) begin
            for (int i = 0; i < 9; i++) begin
                #(bitNs);
                frame[i] = lineFromUnit;
            end
            got.push_back({frame[8], frame[7:0]});
        end
    end
endmodule // spu_peer_model

// File: tb/spu_serial_port_unit_tb.sv
/*
 * spu_serial_port_unit_tb: self-checking bench for the serial port unit.
 * Assumes the bench plays both outside DMA channels and the peer model.
 */
`timescale 1ns/1ps
module spu_serial_port_unit_tb;
    import spu_pkg::*;

    // unit inputs and outputs
    logic                 ref_clk = 1'b0;
    logic                 arst_n = 1'b0;
    logic                 avgRateSel = 1'b0;
    logic                 initiatorStrap = 1'b0;
    logic                 triggerInPin = 1'b1;
    logic                 txInValid = 1'b0;
    logic [7:0]           txInData = 8'h00;
    logic                 rxReadStrobe = 1'b0;
    logic [NUM_FLAGS-1:0] flagClear = '0;
    logic                 triggerOutPin, serialInPin, serialOutPin;
    logic                 txInReady, txEmptyRequest, rxFullRequest;
    logic [7:0]           rxData;
    logic [NUM_FLAGS-1:0] statusFlags;
    logic                 blockActive, txBlockDone, rxBlockDone;
    int                   mismatches = 0, samples_checked = 0;
    int                   txReqCount = 0, rxReqCount = 0;
    int                   txDoneCount = 0, rxDoneCount = 0;

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    spu_serial_port_unit #(.STD_DIV(2)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .avgRateSel(avgRateSel),
        .initiatorStrap(initiatorStrap), .triggerInPin(triggerInPin),
        .triggerOutPin(triggerOutPin), .serialInPin(serialInPin),
        .serialOutPin(serialOutPin), .txInValid(txInValid),
        .txInData(txInData), .txInReady(txInReady), .rxData(rxData),
        .rxReadStrobe(rxReadStrobe), .flagClear(flagClear),
        .statusFlags(statusFlags), .txEmptyRequest(txEmptyRequest),
        .rxFullRequest(rxFullRequest), .blockActive(blockActive),
        .txBlockDone(txBlockDone), .rxBlockDone(rxBlockDone));

    spu_peer_model peer (.lineFromUnit(serialOutPin),
                         .lineToUnit(serialInPin));

    // request pulses counted as the outside channels would see them
    always @(posedge ref_clk) begin
        if (txEmptyRequest === 1'b1) txReqCount++;
        if (rxFullRequest === 1'b1) rxReqCount++;
        if (txBlockDone === 1'b1) txDoneCount++;
        if (rxBlockDone === 1'b1) rxDoneCount++;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        arst_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        txReqCount = 0;
        rxReqCount = 0;
        txDoneCount = 0;
        rxDoneCount = 0;
        peer.got.delete();
        arst_n = 1'b1;
    endtask

    task automatic wait_peer(input int n);
        for (int i = 0; i < 40000 && peer.got.size() < n; i++)
            @(posedge ref_clk);
        chk(16'(peer.got.size()), 16'(n));
    endtask

    // responder: fill the FIFO until refused, then start on trigger
    task automatic t_fill();
        int n;
        n = 0;
        initiatorStrap = 1'b0;
        do_reset();
        chk(statusFlags, FLAGS_RESET);
        chk(serialOutPin, 1'b1);
        while (n < FIFO_DEPTH + 4) begin
            @(negedge ref_clk);
            if (txInReady !== 1'b1) break;
            txInValid = 1'b1;
            txInData = 8'(n + 8'h30);
            n++;
        end
        @(negedge ref_clk);
        txInValid = 1'b0;
        chk(16'(n), 16'(FIFO_DEPTH + 1));
        repeat (100) @(negedge ref_clk);
        chk(blockActive, 1'b0);
        chk(16'(peer.got.size()), 0);
        triggerInPin = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(blockActive, 1'b1);
        wait_peer(n);
        for (int i = 0; i < n; i++)
            chk(16'(peer.got[i]), {1'b1, 8'(i + 8'h30)});
        chk(16'(txReqCount), 16'(n));
        @(negedge ref_clk);
        triggerInPin = 1'b1;
        $display("test fill done");
    endtask

    // full blocks both ways at once; bench plays channels 0 and 1
    task automatic t_block();
        int sent;
        sent = 0;
        initiatorStrap = 1'b1;
        do_reset();
        repeat (3) @(negedge ref_clk);
        chk(blockActive, 1'b1);
        fork
            for (int i = 0; i < BLOCK_BYTES; i++)
                peer.send(8'(i), 1'b1);
            begin
                while (sent < BLOCK_BYTES) begin
                    @(negedge ref_clk);
                    txInValid = (txInReady === 1'b1);
                    txInData = 8'(sent + 8'h40);
                    if (txInReady === 1'b1) sent++;
                end
                @(negedge ref_clk);
                txInValid = 1'b0;
            end
            for (int j = 0; j < BLOCK_BYTES; j++) begin
                do @(negedge ref_clk); while (rxFullRequest !== 1'b1);
                chk(rxData, 8'(j));
                rxReadStrobe = 1'b1;
                @(negedge ref_clk);
                rxReadStrobe = 1'b0;
            end
        join
        wait_peer(BLOCK_BYTES);
        for (int i = 0; i < BLOCK_BYTES; i++)
            chk(16'(peer.got[i]), {1'b1, 8'(i + 8'h40)});
        chk({8'(txReqCount), 8'(rxReqCount)}, 16'h8080);
        chk({8'(txDoneCount), 8'(rxDoneCount)}, 16'h0101);
        @(negedge ref_clk);
        $display("test block done");
    endtask

    // initiator: trigger goes low one edge before blocks start
    task automatic t_init();
        initiatorStrap = 1'b1;
        do_reset();
        @(negedge ref_clk);
        chk({triggerOutPin, blockActive}, 2'b10);
        @(negedge ref_clk);
        chk({triggerOutPin, blockActive}, 2'b00);
        @(negedge ref_clk);
        chk({triggerOutPin, blockActive}, 2'b01);
        $display("test init done");
    endtask

    // receive path: copy, double buffer, overrun, framing, clearing
    task automatic t_rx();
        peer.send(8'h96, 1'b1);
        repeat (4) @(negedge ref_clk);
        chk(rxData, 8'h96);
        chk({statusFlags[FLG_RXF], 8'(rxReqCount)}, 9'h101);
        fork
            peer.send(8'h5A, 1'b1);
            begin
                repeat (200) @(negedge ref_clk);
                rxReadStrobe = 1'b1;
                @(negedge ref_clk);
                rxReadStrobe = 1'b0;
            end
        join
        repeat (4) @(negedge ref_clk);
        chk({rxData, 8'(rxReqCount)}, 16'h5A02);
        chk(statusFlags[FLG_ORR], 1'b0);
        peer.send(8'hC3, 1'b1);
        chk({rxData, 8'(rxReqCount)}, 16'h5A02);
        chk(statusFlags[FLG_ORR], 1'b1);
        @(negedge ref_clk);
        flagClear = NUM_FLAGS'((1 << FLG_ORR) | (1 << FLG_FRM));
        @(negedge ref_clk);
        flagClear = '0;
        repeat (2) @(negedge ref_clk);
        chk({statusFlags[FLG_ORR], statusFlags[FLG_FRM]}, 2'b00);
        peer.send(8'h11, 1'b0);
        chk({rxData, 8'(rxReqCount)}, 16'h5A02);
        chk(statusFlags[FLG_FRM], 1'b1);
        $display("test rx done");
    endtask

    // average generator: nine low bits of a zero byte span 9 bit times
    task automatic t_rate();
        realtime t0, dt, exp;
        @(negedge ref_clk);
        avgRateSel = 1'b1;
        peer.bitNs = 1.0e9 / 921569.0;
        exp = 9.0 * peer.bitNs;
        peer.got.delete();
        while (statusFlags[FLG_TXE] !== 1'b1 || txInReady !== 1'b1)
            @(negedge ref_clk);
        txInValid = 1'b1;
        txInData = 8'h00;
        @(negedge ref_clk);
        txInValid = 1'b0;
        @(negedge serialOutPin);
        t0 = $realtime;
        @(posedge serialOutPin);
        dt = $realtime - t0;
        chk(16'(dt > exp - 100.0 && dt < exp + 100.0), 1);
        wait_peer(1);
        chk(16'(peer.got[0]), 9'h100);
        $display("test rate done");
    endtask

    // main sequence
    initial begin
        t_fill();
        t_block();
        t_init();
        t_rx();
        t_rate();
        results();
    end

    // watchdog well past the expected run of about 250 us
    initial begin
        #350000;
        mismatches++;
        results();
    end
endmodule // spu_serial_port_unit_tb
